// *** inc/tdd_pkg.sv ***
// Package with register map, field positions and timing constants for the transient debounce stage
package tdd_pkg;
  // Register offsets
  localparam logic [7:0] TDD_ADDR_CFG = 8'h1d;
  localparam logic [7:0] TDD_ADDR_SRC = 8'h1e;
  localparam logic [7:0] TDD_ADDR_THS = 8'h1f;
  localparam logic [7:0] TDD_ADDR_CNT = 8'h20;
  // Reset values
  localparam logic [7:0] TDD_THS_RST = 8'h00;
  localparam logic [7:0] TDD_CNT_RST = 8'h00;
  localparam logic [7:0] TDD_CFG_RST = 8'h00;
  // Field positions
  localparam int TDD_MODE_BIT = 7;
  localparam int TDD_ELE_BIT = 4;
  localparam int TDD_ZEN_BIT = 3;
  localparam int TDD_YEN_BIT = 2;
  localparam int TDD_XEN_BIT = 1;
  localparam int TDD_BYP_BIT = 0;
  localparam int TDD_EA_BIT = 6;
  // Threshold scaling: 63 mg per count, samples given in mg
  localparam logic [15:0] TDD_MG_PER_LSB = 16'h003f;
  // Range limit in low-noise mode, 4 g in mg
  localparam logic [15:0] TDD_LN_LIMIT_MG = 16'h0fa0;
  // Data rate codes
  typedef enum logic [2:0] {
    TDD_ODR_800, TDD_ODR_400, TDD_ODR_200, TDD_ODR_100,
    TDD_ODR_50, TDD_ODR_12P5, TDD_ODR_6P25, TDD_ODR_1P56
  } tdd_odr_t;
  // Oversampling power modes
  typedef enum logic [1:0] {
    TDD_OSR_NORMAL, TDD_OSR_LP_LOW_NOISE, TDD_OSR_HIRES, TDD_OSR_LOWPWR
  } tdd_osr_t;
  // Time steps in microseconds
  localparam logic [17:0] TDD_STEP_1P25_US = 18'h0_04e2;
  localparam logic [17:0] TDD_STEP_2P5_US = 18'h0_09c4;
  localparam logic [17:0] TDD_STEP_5_US = 18'h0_1388;
  localparam logic [17:0] TDD_STEP_10_US = 18'h0_2710;
  localparam logic [17:0] TDD_STEP_20_US = 18'h0_4e20;
  localparam logic [17:0] TDD_STEP_80_US = 18'h1_3880;
  localparam logic [17:0] TDD_STEP_160_US = 18'h2_7100;
  // Clock period in nanoseconds and ns per us
  localparam int TDD_CLK_NS = 10;
  localparam int TDD_NS_PER_US = 1000;
  localparam int TDD_CYC_PER_US = TDD_NS_PER_US / TDD_CLK_NS;
endpackage : tdd_pkg

// *** design/tdd_axis_cmp.sv ***
// Per-axis magnitude versus threshold comparator with range clamp
module tdd_axis_cmp
  import tdd_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Sample and controls
  input wire logic signed [15:0] i_sample_mg,
  input wire logic [15:0] i_thr_mg,
  input wire logic i_low_noise,
  // Results
  output logic o_above,
  output logic o_neg
);
  logic [15:0] mag;
  logic [15:0] lim;

  // Magnitude, clamped to 4 g when low noise is on
  always_comb begin
    mag = i_sample_mg[15] ? 16'(-i_sample_mg) : 16'(i_sample_mg);
    lim = (i_low_noise && mag > TDD_LN_LIMIT_MG) ? TDD_LN_LIMIT_MG : mag;
  end

  // Registered compare result
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_above <= 1'b0;
      o_neg <= 1'b0;
    end else begin
      o_above <= lim > i_thr_mg;
      o_neg <= i_sample_mg[15];
    end
  end
endmodule : tdd_axis_cmp

// *** design/tdd_top.sv ***
// Transient threshold and debounce stage with its register slice
// Operation
// - With mode bit 7 clear, a period without the condition decrements the counter.
// - With mode bit 7 set, a period without the condition clears the counter.
// - The low seven threshold bits are an unsigned level of 63 mg per count, independent of range.
// - With low noise set, measured magnitudes are limited to 4 g.
// - The event flag rises only when the counter reaches the programmed count while an enabled axis is above threshold.
// - Normal mode steps are 1.25, 2.5, 5, 10 ms and 20 ms at 50 Hz and slower.
// - High resolution steps 2.5 ms at 400 Hz and below; low-power low-noise 80 ms at 12.5 Hz and below; low power 80 ms at 12.5 Hz and 160 ms below.
// - Response time lies between the programmed count less one and the programmed count, times the selected step, as the tick runs free.
// - An axis flag goes active only when the event fires, for an enabled axis that is above threshold at that step.
// - With latch on, the event flag holds until the source register is read, and that read clears it unless a new event fires in the same cycle.
module tdd_top
  import tdd_pkg::*;
#(
  // Clock cycles per microsecond of debounce step
  parameter int CYC_PER_US = TDD_CYC_PER_US
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Rate and mode selection
  input wire logic [2:0] i_odr_sel,
  input wire logic [1:0] i_osr_sel,
  input wire logic i_low_noise,
  // High-pass and raw samples in mg
  input wire logic signed [15:0] i_hp_x,
  input wire logic signed [15:0] i_hp_y,
  input wire logic signed [15:0] i_hp_z,
  input wire logic signed [15:0] i_raw_x,
  input wire logic signed [15:0] i_raw_y,
  input wire logic signed [15:0] i_raw_z,
  // Status
  output logic o_event,
  output logic [7:0] o_count
);
  logic [7:0] ths_r;
  logic [7:0] cnt_r;
  logic [7:0] cfg_r;
  logic [7:0] src_r;
  logic [7:0] dbc_r;
  logic [7:0] dbc_nxt;
  logic [24:0] tick_r;
  logic [24:0] step_cyc;
  logic tick;
  logic [15:0] thr_mg;
  logic [2:0] above;
  logic [2:0] neg;
  logic cond;
  logic fire;
  logic src_rd;
  logic signed [15:0] smp [3];

  // Time step per data rate and power mode
  function automatic logic [17:0] step_us(input logic [2:0] odr, input logic [1:0] osr);
    logic [17:0] s;
    s = TDD_STEP_20_US;
    case (odr)
      TDD_ODR_800: s = TDD_STEP_1P25_US;
      TDD_ODR_400: s = TDD_STEP_2P5_US;
      TDD_ODR_200: s = TDD_STEP_5_US;
      TDD_ODR_100: s = TDD_STEP_10_US;
      default: s = TDD_STEP_20_US;
    endcase
    if (osr == TDD_OSR_HIRES && odr != TDD_ODR_800) begin
      s = TDD_STEP_2P5_US;
    end else if (osr == TDD_OSR_LP_LOW_NOISE && odr >= TDD_ODR_12P5) begin
      s = TDD_STEP_80_US;
    end else if (osr == TDD_OSR_LOWPWR && odr == TDD_ODR_12P5) begin
      s = TDD_STEP_80_US;
    end else if (osr == TDD_OSR_LOWPWR && odr > TDD_ODR_12P5) begin
      s = TDD_STEP_160_US;
    end
    return s;
  endfunction : step_us

  // Step length in clock cycles
  assign step_cyc = 25'(step_us(i_odr_sel, i_osr_sel)) * 25'(CYC_PER_US);
  assign tick = (tick_r >= step_cyc - 25'd1);

  // Period tick counter
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick ? '0 : tick_r + 25'd1;
    end
  end

  // Threshold scaled to mg
  assign thr_mg = 16'(ths_r[6:0]) * TDD_MG_PER_LSB;

  // Input selection: high-pass unless bypassed
  assign smp[0] = cfg_r[TDD_BYP_BIT] ? i_raw_x : i_hp_x;
  assign smp[1] = cfg_r[TDD_BYP_BIT] ? i_raw_y : i_hp_y;
  assign smp[2] = cfg_r[TDD_BYP_BIT] ? i_raw_z : i_hp_z;

  // Axis comparators
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      tdd_axis_cmp u_cmp (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_sample_mg(smp[g]),
        .i_thr_mg(thr_mg),
        .i_low_noise(i_low_noise),
        .o_above(above[g]),
        .o_neg(neg[g])
      );
    end
  endgenerate

  // Condition over enabled axes
  assign cond = |(above & {cfg_r[TDD_ZEN_BIT], cfg_r[TDD_YEN_BIT], cfg_r[TDD_XEN_BIT]});

  // Debounce next value
  always_comb begin
    dbc_nxt = dbc_r;
    if (cond) begin
      if (dbc_r < cnt_r) begin
        dbc_nxt = dbc_r + 8'h01;
      end
    end else if (ths_r[TDD_MODE_BIT]) begin
      dbc_nxt = 8'h00;
    end else if (dbc_r != 8'h00) begin
      dbc_nxt = dbc_r - 8'h01;
    end
  end
  assign fire = tick && cond && (dbc_nxt == cnt_r);

  // Debounce counter, one step per debounce tick
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dbc_r <= '0;
    end else if (tick) begin
      dbc_r <= dbc_nxt;
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_r <= TDD_CFG_RST;
      ths_r <= TDD_THS_RST;
      cnt_r <= TDD_CNT_RST;
    end else if (i_reg_wr) begin
      if (i_reg_addr == TDD_ADDR_CFG) cfg_r <= i_reg_wdata;
      if (i_reg_addr == TDD_ADDR_THS) ths_r <= i_reg_wdata;
      if (i_reg_addr == TDD_ADDR_CNT) cnt_r <= i_reg_wdata;
    end
  end

  // Read of the source register
  assign src_rd = i_reg_rd && (i_reg_addr == TDD_ADDR_SRC);

  // Source flags; a new event wins over the read clear, latched or not
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      src_r <= 8'h00;
    end else if (fire && !(cfg_r[TDD_ELE_BIT] && src_r[TDD_EA_BIT] && !src_rd)) begin
      src_r <= {1'b0, 1'b1, above[2] & cfg_r[TDD_ZEN_BIT], neg[2], above[1] & cfg_r[TDD_YEN_BIT], neg[1],
                above[0] & cfg_r[TDD_XEN_BIT], neg[0]};
    end else if (src_rd) begin
      src_r <= 8'h00;
    end
  end

  // Read data register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        TDD_ADDR_CFG: o_reg_rdata <= cfg_r;
        TDD_ADDR_SRC: o_reg_rdata <= src_r;
        TDD_ADDR_THS: o_reg_rdata <= ths_r;
        TDD_ADDR_CNT: o_reg_rdata <= cnt_r;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  assign o_event = src_r[TDD_EA_BIT];
  assign o_count = dbc_r;

  // Checks
  AST_CLEAR_MODE: assert property (@(posedge i_clk) disable iff (i_rst)
    tick && !cond && ths_r[TDD_MODE_BIT] |=> dbc_r == 8'h00) else $error("counter not cleared");
  AST_DEC_MODE: assert property (@(posedge i_clk) disable iff (i_rst)
    tick && !cond && !ths_r[TDD_MODE_BIT] && dbc_r != 8'h00 |=> dbc_r == $past(dbc_r) - 8'h01)
    else $error("counter not decremented");
  AST_INC: assert property (@(posedge i_clk) disable iff (i_rst)
    tick && cond && dbc_r < cnt_r |=> dbc_r == $past(dbc_r) + 8'h01) else $error("counter not incremented");
  AST_SAT: assert property (@(posedge i_clk) disable iff (i_rst)
    dbc_r <= cnt_r || $past(i_reg_wr)) else $error("counter beyond target");
  AST_FIRE: assert property (@(posedge i_clk) disable iff (i_rst)
    fire && !cfg_r[TDD_ELE_BIT] |=> o_event) else $error("event not raised");
  AST_NO_FIRE: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_event && !fire |=> !o_event) else $error("event without debounce");
  AST_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
    o_event && !(i_reg_rd && i_reg_addr == TDD_ADDR_SRC) |=> o_event) else $error("event lost");
  AST_READ_CLR: assert property (@(posedge i_clk) disable iff (i_rst)
    o_event && i_reg_rd && i_reg_addr == TDD_ADDR_SRC && !fire |=> !o_event) else $error("read did not clear");
  AST_STEP: assert property (@(posedge i_clk) disable iff (i_rst)
    i_odr_sel == TDD_ODR_800 |-> step_cyc == 25'(CYC_PER_US) * 25'd1250) else $error("wrong 800 Hz step");
  AST_STEP_NORMAL: assert property (@(posedge i_clk) disable iff (i_rst)
    i_osr_sel == TDD_OSR_NORMAL && i_odr_sel == TDD_ODR_100 |-> step_cyc == 25'(CYC_PER_US) * 25'd10000) else $error("wrong normal step");
  AST_STEP_HIRES: assert property (@(posedge i_clk) disable iff (i_rst)
    i_osr_sel == TDD_OSR_HIRES && i_odr_sel != TDD_ODR_800 |-> step_cyc == 25'(CYC_PER_US) * 25'd2500) else $error("wrong hires step");
  AST_STEP_SLOW: assert property (@(posedge i_clk) disable iff (i_rst)
    i_osr_sel == TDD_OSR_LOWPWR && i_odr_sel == TDD_ODR_1P56 |-> step_cyc == 25'(CYC_PER_US) * 25'd160000) else $error("wrong slow step");
  AST_SET_WINS: assert property (@(posedge i_clk) disable iff (i_rst)
    src_rd && fire |=> o_event) else $error("event lost to read clear");
endmodule : tdd_top

// *** verif/tdd_top_test.sv ***
// Self-checking bench for the transient threshold and debounce stage
module tdd_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tdd_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] o_reg_rdata;
  logic [2:0] i_odr_sel = 3'h0;
  logic [1:0] i_osr_sel = 2'h0;
  logic i_low_noise = 1'b0;
  logic signed [15:0] i_hp_x = 16'h0000;
  logic signed [15:0] i_hp_y = 16'h0000;
  logic signed [15:0] i_hp_z = 16'h0000;
  logic signed [15:0] i_raw_x = 16'h0000;
  logic signed [15:0] i_raw_y = 16'h0000;
  logic signed [15:0] i_raw_z = 16'h0000;
  logic o_event;
  logic [7:0] o_count;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int t_prev = 0;
  logic [7:0] rd_val;
  // One cycle per microsecond keeps debounce steps short
  localparam int CYC_US = 1;
  localparam int STEP_FAST = int'(TDD_STEP_1P25_US) * CYC_US;
  localparam int STEP_HIRES = int'(TDD_STEP_2P5_US) * CYC_US;
  localparam int TICK_LIMIT = STEP_HIRES + 100;

  tdd_top #(.CYC_PER_US(CYC_US)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_odr_sel(i_odr_sel), .i_osr_sel(i_osr_sel), .i_low_noise(i_low_noise),
    .i_hp_x(i_hp_x), .i_hp_y(i_hp_y), .i_hp_z(i_hp_z), .i_raw_x(i_raw_x), .i_raw_y(i_raw_y),
    .i_raw_z(i_raw_z), .o_event(o_event), .o_count(o_count));

  // Clock and cycle counter
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;

  // Compare and count
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One-cycle register write
  task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = addr;
    i_reg_wdata = data;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask : reg_wr

  // One-cycle register read, data sampled once settled
  task automatic reg_rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge i_clk);
    i_reg_rd = 1'b1;
    i_reg_addr = addr;
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    @(negedge i_clk);
    data = o_reg_rdata;
  endtask : reg_rd

  // Wait for the counter to move, bounded by one 2.5 ms step plus 100 cycles
  task automatic wait_tick();
    logic [7:0] old;
    int n;
    old = o_count;
    n = 0;
    while (o_count === old && n < TICK_LIMIT) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= TICK_LIMIT) begin
      failures++;
      $display("[ERR] tick expected count change seen none");
    end
  endtask : wait_tick

  // Verdict
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // Watchdog of sixteen 2.5 ms debounce steps, about twice the 21.25 ms of the twelve steps (seven 1.25 ms, five 2.5 ms) the test waits for
  initial begin
    repeat (40000) @(posedge i_clk);
    failures++;
    end_of_test();
  end

  initial begin
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    // Reset values and access kinds
    reg_rd(TDD_ADDR_THS, rd_val); chk("ths reset", rd_val, TDD_THS_RST);
    reg_rd(TDD_ADDR_CNT, rd_val); chk("cnt reset", rd_val, TDD_CNT_RST);
    chk("event reset", {7'h00, o_event}, 8'h00);
    reg_wr(TDD_ADDR_THS, 8'hff);
    reg_rd(TDD_ADDR_THS, rd_val); chk("ths rw", rd_val, 8'hff);
    reg_wr(TDD_ADDR_SRC, 8'hff);
    reg_rd(TDD_ADDR_SRC, rd_val); chk("src read only", rd_val, 8'h00);
    reg_wr(8'h30, 8'h55);
    reg_rd(8'h30, rd_val); chk("unmapped", rd_val, 8'h00);
    // Threshold 2 counts is 126 mg: 120 mg stays below, 200 mg above
    reg_wr(TDD_ADDR_CFG, 8'h12);
    reg_wr(TDD_ADDR_THS, 8'h02);
    reg_wr(TDD_ADDR_CNT, 8'h02);
    reg_rd(TDD_ADDR_CNT, rd_val); chk("cnt rw", rd_val, 8'h02);
    // Above threshold on the enabled axis: count up to the target
    i_hp_x = 16'sd200;
    i_hp_y = 16'sd900;
    wait_tick();
    t_prev = cyc;
    chk("count one", o_count, 8'h01);
    chk("no early event", {7'h00, o_event}, 8'h00);
    wait_tick();
    chk("step cycles", ((cyc - t_prev) == STEP_FAST) ? 8'h01 : 8'h00, 8'h01);
    chk("count two", o_count, 8'h02);
    chk("event at target", {7'h00, o_event}, 8'h01);
    // 120 mg is below 126 mg, so decrement mode counts down
    i_hp_x = 16'sd120;
    wait_tick();
    chk("below ths no count", o_count, 8'h01);
    i_hp_x = 16'sd200;
    wait_tick();
    // Condition lapses with decrement mode
    i_hp_x = 16'sd0;
    wait_tick();
    chk("decrement", o_count, 8'h01);
    chk("latched event", {7'h00, o_event}, 8'h01);
    // Clear mode, restore one count first
    i_hp_x = 16'sd200;
    wait_tick();
    reg_wr(TDD_ADDR_THS, 8'h82);
    i_hp_x = 16'sd0;
    wait_tick();
    chk("clear mode", o_count, 8'h00);
    reg_rd(TDD_ADDR_SRC, rd_val); chk("src flags", rd_val, 8'h42);
    chk("cleared by read", {7'h00, o_event}, 8'h00);
    // High resolution at 100 Hz uses the 2.5 ms step
    i_odr_sel = TDD_ODR_100;
    i_osr_sel = TDD_OSR_HIRES;
    i_hp_x = 16'sd200;
    wait_tick();
    t_prev = cyc;
    wait_tick();
    chk("hires step cycles", ((cyc - t_prev) == STEP_HIRES) ? 8'h01 : 8'h00, 8'h01);
    chk("event after read", {7'h00, o_event}, 8'h01);
    // Low noise limits 5000 mg to 4 g, below the 4095 mg threshold
    reg_wr(TDD_ADDR_THS, 8'hc1);
    i_low_noise = 1'b1;
    i_hp_x = 16'sd5000;
    wait_tick();
    chk("low noise clamp", o_count, 8'h00);
    i_low_noise = 1'b0;
    wait_tick();
    chk("full range above", o_count, 8'h01);
    // Raw samples with latch off: flags follow a negative event
    i_raw_x = -16'sd200;
    reg_wr(TDD_ADDR_THS, 8'h82);
    reg_wr(TDD_ADDR_CFG, 8'h03);
    i_hp_x = 16'sd0;
    wait_tick();
    chk("bypass count", o_count, 8'h02);
    reg_rd(TDD_ADDR_SRC, rd_val); chk("negative flags", rd_val, 8'h43);
    end_of_test();
  end
endmodule : tdd_top_test
